// ---- verilog/timer_event_map.vh ----
// Register map, field positions and action codes of the timer
// event and interrupt control block.
// Assumes APB word access: byte address is four times the index.
//
// Operation
// - Compare buffer valid set on write, cleared by update
// - Period buffer valid set on write, cleared by update
// - Event control holds B action, B enable, A action, A enable
// - B code 3: B level sets count direction
// - B code 4: restart on B rising edge
// - B code 5: restart on any B edge
// - B code 6: restart while B high
// - B enable off ignores input B
// - A code 0: count on A rising edge
// - A code 1: count on any A edge
// - A code 2: count ticks while A high
// - A code 3: count ticks, A sets direction
// - A enable off ignores input A
// - Compare interrupt enables in bits 6 to 4
// - Enable bit 0 enables wrap interrupt
// - Flags share the enable register layout
// - Compare flag set on match, cleared writing one
// - Wrap flag set at top/bottom, cleared writing one

`ifndef TIMER_EVENT_MAP_VH
`define TIMER_EVENT_MAP_VH

// ----------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------
`define EVENT_INPUT_CONTROL_IDX 6'h09
`define INTERRUPT_ENABLE_IDX    6'h0a
`define INTERRUPT_FLAGS_IDX     6'h0b
`define BUFFER_VALID_IDX        6'h07

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define REG_RESET               8'h00
`define INTR_MASK               8'h71
`define BUFFER_VALID_MASK       8'h0f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IN_B_ACT_HI             7
`define IN_B_ACT_LO             5
`define IN_B_EN_BIT             4
`define IN_A_ACT_HI             3
`define IN_A_ACT_LO             1
`define IN_A_EN_BIT             0
`define COMPARE_CHANNEL_2_BIT                6
`define COMPARE_CHANNEL_1_BIT                5
`define COMPARE_CHANNEL_0_BIT                4
`define WRAP_BIT                0

// ----------------------------------------------------------------
// Action codes
// ----------------------------------------------------------------
`define B_ACT_NONE              3'h0
`define B_ACT_SETS_DIRECTION    3'h3
`define B_ACT_RESTART_ON_RISE   3'h4
`define B_ACT_RESTART_ON_EDGE   3'h5
`define B_ACT_RESTART_WHILE_HI  3'h6
`define A_ACT_COUNT_ON_RISE     3'h0
`define A_ACT_COUNT_ON_EDGE     3'h1
`define A_ACT_COUNT_WHILE_HIGH  3'h2
`define A_ACT_SETS_DIRECTION    3'h3

`endif

// ---- verilog/event_input_sync.v ----
// Two-stage synchroniser with edge detection for one event line.
// Assumes the event line is asynchronous to pclk.
module event_input_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire event_in,
  output wire level,
  output wire rise,
  output wire fall
);

  reg stage1;
  reg stage2;
  reg stage3;

  // ----------------------------------------------------------------
  // Synchroniser and history
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= event_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~stage3;
  assign fall  = ~stage2 & stage3;

endmodule

// ---- verilog/timer_event_and_irq_control.v ----
// Event action selection, buffer valid tracking and interrupt
// flags of a 16-bit timer, with an APB register slave.
// Assumes counter core, compare and update logic run on pclk and
// event inputs arrive asynchronously from the event system.
//
// Implementation choice: the APB interface to the registers.
`include "timer_event_map.vh"

module timer_event_and_irq_control #(
  parameter ADDR_W = 8
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg               pready,
  output reg  [31:0]       prdata,
  output reg               pslverr,
  input  wire              event_a,
  input  wire              event_b,
  input  wire              prescale_tick,
  input  wire [2:0]        compare_buffer_write,
  input  wire              period_buffer_write,
  input  wire              update_condition,
  input  wire [2:0]        compare_match,
  input  wire              wrap_condition,
  output reg               count_step,
  output reg               count_down,
  output reg               counter_restart,
  output reg  [3:0]        buffer_valid,
  output reg  [3:0]        irq_request
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function addr_hit;
    input [ADDR_W-1:0] addr;
    input [5:0]        idx;
    reg   [ADDR_W-1:0] word_addr;
    begin
      // Byte address of the word, upper bits zero for any ADDR_W of 8 or more
      word_addr      = {ADDR_W{1'b0}};
      word_addr[7:2] = idx;
      addr_hit       = (addr == word_addr);
    end
  endfunction

  function edge_hit;
    input any_edge;
    input rise;
    input fall;
    begin
      edge_hit = rise | (any_edge & fall);
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0] event_input_control;
  reg  [7:0] interrupt_enable;
  reg  [7:0] interrupt_flags;
  reg  [7:0] next_flags;
  reg  [3:0] next_buffer_valid;
  reg        next_count;
  reg        next_down;
  reg        next_restart;
  reg  [7:0] read_mux;
  reg        mapped;

  // ----------------------------------------------------------------
  // Event input synchronisers
  // ----------------------------------------------------------------
  wire a_level;
  wire a_rise;
  wire a_fall;
  wire b_level;
  wire b_rise;
  wire b_fall;

  event_input_sync u_sync_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_in (event_a),
    .level    (a_level),
    .rise     (a_rise),
    .fall     (a_fall)
  );

  event_input_sync u_sync_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_in (event_b),
    .level    (b_level),
    .rise     (b_rise),
    .fall     (b_fall)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire setup_phase = psel & ~penable;
  wire access      = psel & penable & pready;
  wire wr_access   = access & pwrite;

  // Misaligned addresses miss every register and answer with an error
  wire hit_evt   = addr_hit(paddr, `EVENT_INPUT_CONTROL_IDX);
  wire hit_ien   = addr_hit(paddr, `INTERRUPT_ENABLE_IDX);
  wire hit_flags = addr_hit(paddr, `INTERRUPT_FLAGS_IDX);
  wire hit_bv    = addr_hit(paddr, `BUFFER_VALID_IDX);

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  // field extraction
  wire [2:0] b_action = event_input_control[`IN_B_ACT_HI:`IN_B_ACT_LO];
  wire       b_enable = event_input_control[`IN_B_EN_BIT];
  wire [2:0] a_action = event_input_control[`IN_A_ACT_HI:`IN_A_ACT_LO];
  wire       a_enable = event_input_control[`IN_A_EN_BIT];

  wire b_sets_dir = b_enable & (b_action == `B_ACT_SETS_DIRECTION);
  wire a_sets_dir = a_enable & (a_action == `A_ACT_SETS_DIRECTION);

  // ----------------------------------------------------------------
  // Count source from input A
  // ----------------------------------------------------------------
  always @* begin
    next_count = 1'b0;
    if (!a_enable) begin
      next_count = prescale_tick;
    end else begin
      case (a_action)
        `A_ACT_COUNT_ON_RISE: begin
          next_count = edge_hit(1'b0, a_rise, a_fall);
        end
        `A_ACT_COUNT_ON_EDGE: begin
          next_count = edge_hit(1'b1, a_rise, a_fall);
        end
        `A_ACT_COUNT_WHILE_HIGH: begin
          next_count = prescale_tick & a_level;
        end
        `A_ACT_SETS_DIRECTION: begin
          next_count = prescale_tick;
        end
        default: begin
          next_count = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Direction latched at each count
  // ----------------------------------------------------------------
  always @* begin
    // Without a direction source the last direction is kept
    next_down = count_down;
    if (next_count) begin
      // B takes precedence when both set the direction
      // B level sets direction
      if (b_sets_dir) begin
        next_down = b_level;
      end else if (a_sets_dir) begin
        next_down = a_level;
      end
    end
  end

  // ----------------------------------------------------------------
  // Restart from input B
  // ----------------------------------------------------------------
  always @* begin
    next_restart = 1'b0;
    if (b_enable) begin
      case (b_action)
        `B_ACT_RESTART_ON_RISE: begin
          next_restart = edge_hit(1'b0, b_rise, b_fall);
        end
        `B_ACT_RESTART_ON_EDGE: begin
          next_restart = edge_hit(1'b1, b_rise, b_fall);
        end
        `B_ACT_RESTART_WHILE_HI: begin
          next_restart = b_level;
        end
        default: begin
          next_restart = 1'b0;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_step      <= 1'b0;
      count_down      <= 1'b0;
      counter_restart <= 1'b0;
    end else begin
      count_step      <= next_count;
      count_down      <= next_down;
      counter_restart <= next_restart;
    end
  end

  // ----------------------------------------------------------------
  // Buffer valid tracking
  // ----------------------------------------------------------------
  always @* begin
    next_buffer_valid = buffer_valid;
    if (update_condition) begin
      next_buffer_valid = 4'h0;
    end
    // A write in the update cycle leaves its bit set
    // compare buffer write sets valid
    next_buffer_valid = next_buffer_valid |
                        {compare_buffer_write, period_buffer_write};
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_valid <= 4'h0;
    end else begin
      buffer_valid <= next_buffer_valid;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  wire [7:0] flag_set   = {1'b0, compare_match, 3'b000, wrap_condition};
  // Only bits written as one are cleared
  wire [7:0] flag_clear = (wr_access & hit_flags) ?
                          (pwdata[7:0] & `INTR_MASK) : 8'h00;

  always @* begin
    // compare flags, set wins over clear
    // wrap flag, set wins over clear
    next_flags = ((interrupt_flags & ~flag_clear) | flag_set) & `INTR_MASK;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_flags <= `REG_RESET;
    end else begin
      interrupt_flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  // Registered so each request is a flop output
  wire [7:0] pending = interrupt_flags & interrupt_enable;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 4'h0;
    end else begin
      irq_request <= {pending[`COMPARE_CHANNEL_2_BIT], pending[`COMPARE_CHANNEL_1_BIT],
                      pending[`COMPARE_CHANNEL_0_BIT], pending[`WRAP_BIT]};
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_input_control <= `REG_RESET;
    end else begin
      if (wr_access & hit_evt) begin
        event_input_control <= pwdata[7:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable <= `REG_RESET;
    end else begin
      if (wr_access & hit_ien) begin
        interrupt_enable <= pwdata[7:0] & `INTR_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and error, prepared in the setup cycle
  // ----------------------------------------------------------------
  always @* begin
    read_mux = 8'h00;
    mapped   = 1'b1;
    if (hit_evt) begin
      read_mux = event_input_control;
    end else if (hit_ien) begin
      read_mux = interrupt_enable;
    end else if (hit_flags) begin
      read_mux = interrupt_flags;
    end else if (hit_bv) begin
      read_mux = {4'h0, buffer_valid};
    end else begin
      mapped = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      // Zero wait states once out of reset
      pready <= 1'b1;
      if (setup_phase) begin
        prdata  <= pwrite ? 32'h00000000 : {24'h000000, read_mux};
        pslverr <= ~mapped;
      end else if (access) begin
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

endmodule

// ---- dv/timer_event_checker.sv ----
// Concurrent checks on the timer event and interrupt block ports.
// Assumes binding to the top module; shadows enable and control writes.
module timer_event_checker #(
  parameter ADDR_W = 8
) (
  input logic              pclk,
  input logic              presetn,
  input logic              psel,
  input logic              penable,
  input logic              pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0]       pwdata,
  input logic              pready,
  input logic [31:0]       prdata,
  input logic              pslverr,
  input logic              event_a,
  input logic              event_b,
  input logic              prescale_tick,
  input logic [2:0]        compare_buffer_write,
  input logic              period_buffer_write,
  input logic              update_condition,
  input logic [2:0]        compare_match,
  input logic              wrap_condition,
  input logic              count_step,
  input logic              count_down,
  input logic              counter_restart,
  input logic [3:0]        buffer_valid,
  input logic [3:0]        irq_request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl_h;
  logic [7:0] en_h;
  // ----------------------------------------------------------------
  // Register shadows and properties
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_h <= 8'h00;
      en_h   <= 8'h00;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == 8'h24) ctrl_h <= pwdata[7:0];
      if (paddr == 8'h28) en_h <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wrap_seen_s;
    wrap_condition && en_h[0] ##1 en_h[0];
  endsequence
  sequence b_off_s;
    !ctrl_h[4] [*4];
  endsequence
  ready_up_a: assert property ($past(presetn) |-> pready)
    else $error("pready low after reset");
  per_valid_set_a: assert property (period_buffer_write |=> buffer_valid[0])
    else $error("period valid not set");
  valid_clear_a: assert property (update_condition && !period_buffer_write &&
    compare_buffer_write == 3'h0 |=> buffer_valid == 4'h0) else $error("valid not cleared");
  cmp_valid_set_a: assert property (compare_buffer_write[1] |=> buffer_valid[2])
    else $error("compare valid not set");
  wrap_irq_a: assert property (wrap_seen_s |=> irq_request[0])
    else $error("wrap request missing");
  cmp_irq_a: assert property (compare_match[2] && en_h[6] ##1 en_h[6]
    |=> irq_request[3]) else $error("compare request missing");
  irq_mask_a: assert property (!en_h[4] |=> !irq_request[1])
    else $error("masked request raised");
  a_off_tick_a: assert property (!ctrl_h[0] |=> count_step == $past(prescale_tick))
    else $error("count step ignores tick");
  b_off_quiet_a: assert property (b_off_s |-> !counter_restart)
    else $error("restart while input b off");
  unmapped_err_a: assert property (psel && !penable &&
    !(paddr inside {8'h1c, 8'h24, 8'h28, 8'h2c}) |=> pslverr) else $error("no slave error");
endmodule

bind timer_event_and_irq_control timer_event_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- dv/event_pulse_model.sv ----
// Event system channel model: a burst of pulses, four high, four low.
// Assumes start is a one-cycle request on pclk; line idles low.
module event_pulse_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       start,
  input  wire [3:0] n,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt;
  logic [3:0] left;
  // ----------------------------------------------------------------
  // Pulse train
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 3'h0;
      left <= 4'h0;
      line <= 1'b0;
    end else if (start) begin
      cnt  <= 3'h0;
      left <= n;
    end else if (left != 4'h0) begin
      line <= !cnt[2];
      cnt  <= cnt + 3'h1;
      if (cnt == 3'h7) left <= left - 4'h1;
    end else begin
      line <= 1'b0;
    end
  end
endmodule

// ---- dv/timer_event_and_irq_control_tb.sv ----
// Self-checking bench for the timer event and interrupt block.
// Assumes an APB master in the bench and two event channel models.
module timer_event_and_irq_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        event_a, event_b, prescale_tick, period_buffer_write;
  logic        update_condition, wrap_condition, count_step, count_down;
  logic        counter_restart, sa, sb;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [2:0]  compare_buffer_write, compare_match;
  logic [3:0]  buffer_valid, irq_request, na, nb;
  int          n_mismatch, compares, steps, rsts, downs, s0, r0, d0, n;
  timer_event_and_irq_control #(.ADDR_W(8)) u_dut (.*);
  event_pulse_model u_ev_a (.pclk(pclk), .presetn(presetn), .start(sa), .n(na), .line(event_a));
  event_pulse_model u_ev_b (.pclk(pclk), .presetn(presetn), .start(sb), .n(nb), .line(event_b));
  // ----------------------------------------------------------------
  // Clock, watchdog, helpers
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
  always @(posedge pclk) begin
    steps <= steps + count_step;
    rsts  <= rsts + counter_restart;
    downs <= downs + count_down;
  end
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input logic [2:0] cw, input logic pw, input logic up, input logic [2:0] cm,
             input logic wr);
    @(posedge pclk);
    compare_buffer_write <= cw;
    period_buffer_write  <= pw;
    update_condition     <= up;
    compare_match        <= cm;
    wrap_condition       <= wr;
    @(posedge pclk);
    {compare_buffer_write, period_buffer_write, update_condition, compare_match} <= 8'h00;
    wrap_condition <= 1'b0;
  endtask
  task run(input logic [7:0] c, input logic tk, input logic [3:0] a, input logic [3:0] b);
    apb(1'b1, 8'h24, {24'h0, c});
    s0 = steps;
    r0 = rsts;
    d0 = downs;
    @(posedge pclk);
    prescale_tick <= tk;
    na <= a;
    nb <= b;
    sa <= 1'b1;
    sb <= 1'b1;
    @(posedge pclk);
    sa <= 1'b0;
    sb <= 1'b0;
    repeat (39) @(posedge pclk);
    prescale_tick <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  function automatic int exp_a(input int c, input int k);
    case (c)
      0: return k;
      1: return 2 * k;
      2: return 4 * k;
      3: return 40;
      default: return 0;
    endcase
  endfunction
  function automatic int exp_b(input int c, input int e, input int k);
    if (e == 0) return 0;
    case (c)
      4: return k;
      5: return 2 * k;
      6: return 4 * k;
      default: return 0;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, prescale_tick, sa, sb} = 7'h00;
    {period_buffer_write, update_condition, wrap_condition} = 3'h0;
    {compare_buffer_write, compare_match, na, nb} = 14'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(28570));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i == 0 ? 28 : 32 + i * 4), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    v = $urandom;
    apb(1'b1, 8'h24, v);
    apb(1'b0, 8'h24, 32'h0);
    chk("event control", rd, {24'h0, v[7:0]});
    apb(1'b1, 8'h28, 32'hff);
    apb(1'b0, 8'h28, 32'h0);
    chk("irq enable", rd, 32'h71);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped error", er, 32'h1);
    pulse(v[10:8], v[11], 1'b0, 3'h0, 1'b0);
    apb(1'b0, 8'h1c, 32'h0);
    chk("buffer valid", rd, {28'h0, v[10:8], v[11]});
    pulse(3'h0, 1'b0, 1'b1, 3'h0, 1'b0);
    apb(1'b0, 8'h1c, 32'h0);
    chk("valid cleared", rd, 32'h0);
    pulse(3'h0, 1'b0, 1'b0, 3'h7, 1'b1);
    apb(1'b0, 8'h2c, 32'h0);
    chk("flags", rd, 32'h71);
    chk("irq all", irq_request, 4'hf);
    apb(1'b1, 8'h2c, 32'h11);
    apb(1'b0, 8'h2c, 32'h0);
    chk("flags after clear", rd, 32'h60);
    chk("irq after clear", irq_request, 4'hc);
    apb(1'b1, 8'h28, 32'h01);
    pulse(3'h0, 1'b0, 1'b0, 3'h7, 1'b0);
    chk("irq masked", irq_request, 4'h0);
    apb(1'b1, 8'h2c, 32'hff);
    for (int c = 0; c < 8; c++) begin
      n = $urandom_range(3, 1);
      run({4'h0, 3'(c), 1'b1}, c >= 2, 4'(n), 4'h0);
      chk("a steps", steps - s0, exp_a(c, n));
      if (c == 3) chk("a down", downs != d0, 32'h1);
    end
    for (int i = 0; i < 16; i++) begin
      n = $urandom_range(3, 1);
      run({3'(i), 1'(i >> 3), 4'h0}, 1'b1, 4'(n), 4'(n));
      v = exp_b(i % 8, i / 8, n);
      chk("b restarts", rsts - r0, v);
      chk("a off steps", steps - s0, 32'd40);
    end
    run(8'h77, 1'b1, 4'h0, 4'h2);
    chk("b steps", steps - s0, 32'd40);
    chk("b down", downs != d0, 32'h1);
    print_verdict;
  end
endmodule
